// ---- inc/pcitgt_defines.svh ----
// constants of the bus target: commands, config offsets, fields, resets
`ifndef PCITGT_DEFINES_SVH
`define PCITGT_DEFINES_SVH
// ==================================================================
// bus commands, active high encoding as sampled on the c/be lines
`define PT_CMD_SPECIAL 4'h1
`define PT_CMD_IO_READ 4'h2
`define PT_CMD_IO_WRITE 4'h3
`define PT_CMD_CFG_READ 4'hA
`define PT_CMD_CFG_WRITE 4'hB
// ==================================================================
// configuration dword indices
`define PT_CFG_ID 6'h00
`define PT_CFG_CMDSTAT 6'h01
`define PT_CFG_BAR0 6'h04
// ==================================================================
// command and status fields
`define PT_CMD_IO_EN_BIT 0
`define PT_CMD_PERR_RESP_BIT 6
`define PT_CMD_SERR_EN_BIT 8
`define PT_STAT_SERR_SIG_BIT 30
`define PT_STAT_PERR_DET_BIT 31
// ==================================================================
// reset values
`define PT_CMD_RESET 16'h0000
`define PT_BAR_RESET 32'h0000_0000
`endif

// ---- inc/pcitgt_pkg.sv ----
// types shared by the bus target modules
package pcitgt_pkg;
   typedef enum logic [2:0] {
      PT_IDLE = 3'b000,
      PT_DECODE = 3'b001,
      PT_DATA = 3'b010,
      PT_XFER = 3'b011,
      PT_TURN = 3'b100,
      PT_IGNORE = 3'b101
   } pcitgt_state_type;
endpackage

// ---- inc/pcitgt_cfg_if.sv ----
// carrier between the bus engine and the configuration space
`timescale 1ns/10ps
`default_nettype none
interface pcitgt_cfg_if;
   logic wr;
   logic [5:0] idx;
   logic [31:0] wdata;
   logic [3:0] be_n;
   logic [31:0] rdata;
   logic perr_evt;
   logic serr_evt;
   logic io_en;
   logic perr_resp;
   logic serr_en;
   logic [31:0] bar;
   modport engine (output wr, idx, wdata, be_n, perr_evt, serr_evt,
      input rdata, io_en, perr_resp, serr_en, bar);
   modport cfg (input wr, idx, wdata, be_n, perr_evt, serr_evt,
      output rdata, io_en, perr_resp, serr_en, bar);
endinterface
`default_nettype wire

// ---- hw/pcitgt_parity.sv ----
// even parity over address/data and command/byte-enable lines
`timescale 1ns/10ps
`default_nettype none
module pcitgt_parity (
   input wire logic [31:0] word,
   input wire logic [3:0] cbe,
   output logic par
);
   // even parity: the 37 lines together hold an even number of ones
   assign par = ^{word, cbe};
endmodule
`default_nettype wire

// ---- hw/pcitgt_cfg.sv ----
// configuration space: identity, command/status, one i/o window
`timescale 1ns/10ps
`default_nettype none
`include "pcitgt_defines.svh"
module pcitgt_cfg #(
   parameter logic [15:0] VENDOR_CODE = 16'h0F0F, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0001, // arbitrary value
   parameter int IO_BITS = 5
) (
   input wire logic clock,
   input wire logic srst,
   pcitgt_cfg_if.cfg cfg
);
   logic [15:0] cmd_reg;
   logic [31:0] bar_reg;
   logic perr_det_reg;
   logic serr_sig_reg;
   logic cmd_hit;
   logic bar_hit;
   assign cmd_hit = cfg.wr && cfg.idx == `PT_CFG_CMDSTAT;
   assign bar_hit = cfg.wr && cfg.idx == `PT_CFG_BAR0;
   // ==================================================================
   // byte-wise writes
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         always_ff @(posedge clock) begin
            if (srst) begin
               bar_reg[8*b+7 -: 8] <= 8'(`PT_BAR_RESET >> (8*b));
            end else if (bar_hit && !cfg.be_n[b]) begin
               bar_reg[8*b+7 -: 8] <= cfg.wdata[8*b+7 -: 8];
            end
         end
         if (b < 2) begin : g_cmd
            always_ff @(posedge clock) begin
               if (srst) begin
                  cmd_reg[8*b+7 -: 8] <= 8'(`PT_CMD_RESET >> (8*b));
               end else if (cmd_hit && !cfg.be_n[b]) begin
                  cmd_reg[8*b+7 -: 8] <= cfg.wdata[8*b+7 -: 8];
               end
            end
         end
      end
   endgenerate
   // ==================================================================
   // sticky error status, write one to clear; a new event beats the clear
   always_ff @(posedge clock) begin
      if (srst) begin
         perr_det_reg <= 1'b0;
         serr_sig_reg <= 1'b0;
      end else begin
         if (cfg.perr_evt) begin
            perr_det_reg <= 1'b1;
         end else if (cmd_hit && !cfg.be_n[3] &&
               cfg.wdata[`PT_STAT_PERR_DET_BIT]) begin
            perr_det_reg <= 1'b0;
         end
         if (cfg.serr_evt) begin
            serr_sig_reg <= 1'b1;
         end else if (cmd_hit && !cfg.be_n[3] &&
               cfg.wdata[`PT_STAT_SERR_SIG_BIT]) begin
            serr_sig_reg <= 1'b0;
         end
      end
   end
   // ==================================================================
   // read side
   always_comb begin
      cfg.rdata = 32'h0000_0000;
      unique case (cfg.idx)
         `PT_CFG_ID: cfg.rdata = {DEVICE_CODE, VENDOR_CODE};
         `PT_CFG_CMDSTAT: begin
            cfg.rdata[15:0] = cmd_reg;
            cfg.rdata[`PT_STAT_PERR_DET_BIT] = perr_det_reg;
            cfg.rdata[`PT_STAT_SERR_SIG_BIT] = serr_sig_reg;
         end
         `PT_CFG_BAR0: cfg.rdata = cfg.bar;
         default: cfg.rdata = 32'h0000_0000;
      endcase
   end
   // low bits read zero, bit 0 marks an i/o window
   assign cfg.bar = {bar_reg[31:IO_BITS], {(IO_BITS-1){1'b0}}, 1'b1};
   assign cfg.io_en = cmd_reg[`PT_CMD_IO_EN_BIT];
   assign cfg.perr_resp = cmd_reg[`PT_CMD_PERR_RESP_BIT];
   assign cfg.serr_en = cmd_reg[`PT_CMD_SERR_EN_BIT];
endmodule
`default_nettype wire

// ---- hw/pcitgt_top.sv ----
// bus target engine: decode, handshake, data transfer, parity report
`timescale 1ns/10ps
`default_nettype none
`include "pcitgt_defines.svh"
// Contract
// R1: reset puts every register, the sequencer and every output in a known state.
// R2: during reset the address/data lines and the system error pin are not driven.
// R3: a transaction is one address phase carrying the address, then data phases.
// R4: write data is taken only in a clock where initiator and target ready are both low.
// R5: the initiator holds frame low from the start for as long as data is to move.
// R6: the initiator asserts its ready only with valid write data or room for read data.
// R7: target ready is asserted only when the device can complete the data phase.
// R8: stop is asserted when the device wants the initiator to end on this data phase.
// R9: lock marks an atomic operation driven by the initiator and watched by the device.
// R10: configuration cycles are claimed only while the id select input is high.
// R11: device select is driven low after an own address decode and floats otherwise.
// R12: the parity error pin reports data parity errors.
// R13: parity error is held low at least one clock and never for special cycles.
// R14: system error is pulled low on an address parity error.
// R15: parity is even over 36 lines, one clock after address or the ready that moves data.
// R16: the c/be lines carry the command in the address phase, byte enables after it.
// R17: the target pins are driven high one clock before they are released.
module pcitgt_top #(
   parameter int IO_BITS = 5
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [31:0] ad_in,
   output logic [31:0] ad_out,
   output logic ad_oe,
   input wire logic [3:0] cbe_n,
   input wire logic par_in,
   output logic par_out,
   output logic par_oe,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic lock_n,
   input wire logic idsel,
   output logic trdy_n,
   output logic trdy_oe,
   output logic stop_n,
   output logic stop_oe,
   output logic devsel_n,
   output logic devsel_oe,
   output logic perr_n,
   output logic perr_oe,
   output logic system_error_out_n,
   output logic system_error_oe,
   output logic io_rd,
   output logic io_wr,
   output logic [IO_BITS-1:0] io_addr,
   output logic [31:0] io_wdata,
   output logic [3:0] io_be_n,
   input wire logic [31:0] io_rdata,
   output logic atomic_active
);
   pcitgt_pkg::pcitgt_state_type state_reg;
   logic frame_prev_reg;
   logic [31:0] addr_reg;
   logic [3:0] cmd_reg;
   logic idsel_reg;
   logic is_cfg_reg;
   logic is_read_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wbe_reg;
   logic wchk_reg;
   logic [1:0] perr_phase_reg;
   logic hit;
   logic is_cfg;
   logic addr_start;
   logic xfer;
   logic chk_par;
   logic gen_par;
   logic addr_perr;
   logic data_perr;
   pcitgt_cfg_if cfg_bus ();
   // ==================================================================
   // decode helpers
   function automatic logic cmd_is_cfg(input logic [3:0] c);
      return c == `PT_CMD_CFG_READ || c == `PT_CMD_CFG_WRITE;
   endfunction
   function automatic logic cmd_is_io(input logic [3:0] c);
      return c == `PT_CMD_IO_READ || c == `PT_CMD_IO_WRITE;
   endfunction
   // a falling frame in idle is the address phase
   assign addr_start = state_reg == pcitgt_pkg::PT_IDLE && !frame_n &&
      frame_prev_reg; // R3 R5
   assign is_cfg = cmd_is_cfg(cmd_reg) && idsel_reg; // R10
   assign hit = is_cfg || (cmd_is_io(cmd_reg) && cfg_bus.io_en &&
      addr_reg[31:IO_BITS] == cfg_bus.bar[31:IO_BITS]); // R11
   // data moves only when both ready lines are low at the edge
   assign xfer = state_reg == pcitgt_pkg::PT_XFER && !irdy_n &&
      !trdy_n; // R4 R6
   // ==================================================================
   // parity: one checker shared by address and write data, one generator
   pcitgt_parity u_chk (
      .word(state_reg == pcitgt_pkg::PT_DECODE ? addr_reg : wdata_reg),
      .cbe(state_reg == pcitgt_pkg::PT_DECODE ? cmd_reg : wbe_reg),
      .par(chk_par)
   );
   pcitgt_parity u_gen (
      .word(ad_out),
      .cbe(cbe_n),
      .par(gen_par)
   );
   // special cycles carry no data parity report
   assign addr_perr = state_reg == pcitgt_pkg::PT_DECODE &&
      chk_par != par_in; // R15
   assign data_perr = wchk_reg && chk_par != par_in &&
      cmd_reg != `PT_CMD_SPECIAL; // R13 R15
   pcitgt_cfg #(
      .IO_BITS(IO_BITS)
   ) u_cfg (
      .clock(clock),
      .srst(srst),
      .cfg(cfg_bus)
   );
   // ==================================================================
   // address phase capture
   always_ff @(posedge clock) begin
      if (srst) begin
         frame_prev_reg <= 1'b1;
         addr_reg <= 32'h0000_0000;
         cmd_reg <= 4'h0;
         idsel_reg <= 1'b0;
      end else begin
         frame_prev_reg <= frame_n;
         if (addr_start) begin
            addr_reg <= ad_in; // R3
            cmd_reg <= cbe_n; // R16
            idsel_reg <= idsel;
         end
      end
   end
   // ==================================================================
   // sequencer
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= pcitgt_pkg::PT_IDLE; // R1
         is_cfg_reg <= 1'b0;
         is_read_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            pcitgt_pkg::PT_IDLE: begin
               if (addr_start) begin
                  state_reg <= pcitgt_pkg::PT_DECODE;
               end
            end
            pcitgt_pkg::PT_DECODE: begin
               is_cfg_reg <= is_cfg;
               is_read_reg <= !cmd_reg[0];
               state_reg <= hit ? pcitgt_pkg::PT_DATA :
                  pcitgt_pkg::PT_IGNORE;
            end
            pcitgt_pkg::PT_DATA: state_reg <= pcitgt_pkg::PT_XFER;
            pcitgt_pkg::PT_XFER: begin
               // a vanished initiator also ends the claim
               if (xfer || (frame_n && irdy_n)) begin
                  state_reg <= pcitgt_pkg::PT_TURN;
               end
            end
            pcitgt_pkg::PT_TURN: state_reg <= pcitgt_pkg::PT_IDLE;
            pcitgt_pkg::PT_IGNORE: begin
               if (frame_n && irdy_n) begin
                  state_reg <= pcitgt_pkg::PT_IDLE;
               end
            end
            default: state_reg <= pcitgt_pkg::PT_IDLE;
         endcase
      end
   end
   // ==================================================================
   // target handshake pins
   always_ff @(posedge clock) begin
      if (srst) begin
         devsel_n <= 1'b1; // R1
         devsel_oe <= 1'b0;
         trdy_n <= 1'b1;
         trdy_oe <= 1'b0;
         stop_n <= 1'b1;
         stop_oe <= 1'b0;
      end else if (state_reg == pcitgt_pkg::PT_DECODE && hit) begin
         devsel_n <= 1'b0; // R11
         devsel_oe <= 1'b1;
         trdy_n <= 1'b1;
         trdy_oe <= 1'b1;
         stop_n <= 1'b1;
         stop_oe <= 1'b1;
      end else if (state_reg == pcitgt_pkg::PT_DATA) begin
         // read data is loaded at this edge, so ready is honest
         trdy_n <= 1'b0; // R7
         // single dword per claim: disconnect with data
         stop_n <= 1'b0; // R8
      end else if (state_reg == pcitgt_pkg::PT_XFER &&
            (xfer || (frame_n && irdy_n))) begin
         devsel_n <= 1'b1; // R17
         trdy_n <= 1'b1;
         stop_n <= 1'b1;
      end else if (state_reg == pcitgt_pkg::PT_TURN) begin
         devsel_oe <= 1'b0; // R17
         trdy_oe <= 1'b0;
         stop_oe <= 1'b0;
      end
   end
   // ==================================================================
   // address/data drive and read parity
   always_ff @(posedge clock) begin
      if (srst) begin
         ad_out <= 32'h0000_0000;
         ad_oe <= 1'b0; // R2
         par_out <= 1'b0;
         par_oe <= 1'b0;
      end else begin
         if (state_reg == pcitgt_pkg::PT_DECODE) begin
            ad_oe <= hit && !cmd_reg[0];
            ad_out <= 32'h0000_0000;
         end else if (state_reg == pcitgt_pkg::PT_DATA && is_read_reg) begin
            ad_out <= is_cfg_reg ? cfg_bus.rdata : io_rdata;
         end else if (state_reg == pcitgt_pkg::PT_XFER && xfer) begin
            ad_oe <= 1'b0;
         end else if (state_reg == pcitgt_pkg::PT_XFER && frame_n &&
               irdy_n) begin
            ad_oe <= 1'b0;
         end
         // parity follows the lines it covers by one clock
         par_out <= gen_par; // R15
         par_oe <= ad_oe;
      end
   end
   // ==================================================================
   // write capture and back-end strobes
   assign cfg_bus.wr = xfer && is_cfg_reg && !is_read_reg; // R4 R10
   assign cfg_bus.idx = addr_reg[7:2];
   assign cfg_bus.wdata = ad_in;
   assign cfg_bus.be_n = cbe_n; // R16
   assign cfg_bus.perr_evt = data_perr || addr_perr;
   assign cfg_bus.serr_evt = addr_perr && cfg_bus.serr_en &&
      cfg_bus.perr_resp;
   always_ff @(posedge clock) begin
      if (srst) begin
         io_rd <= 1'b0;
         io_wr <= 1'b0;
         io_addr <= '0;
         io_wdata <= 32'h0000_0000;
         io_be_n <= 4'hF;
         wdata_reg <= 32'h0000_0000;
         wbe_reg <= 4'hF;
         wchk_reg <= 1'b0;
      end else begin
         // read strobe one clock before the data is sampled
         io_rd <= state_reg == pcitgt_pkg::PT_DECODE && hit && !is_cfg &&
            !cmd_reg[0];
         io_wr <= xfer && !is_cfg_reg && !is_read_reg; // R4
         wchk_reg <= xfer && !is_read_reg;
         if (state_reg == pcitgt_pkg::PT_DECODE) begin
            io_addr <= addr_reg[IO_BITS-1:0];
         end
         if (xfer) begin
            io_wdata <= ad_in; // R4
            io_be_n <= cbe_n; // R16
            wdata_reg <= ad_in;
            wbe_reg <= cbe_n;
         end
      end
   end
   // ==================================================================
   // error pins; parity error is driven high for one clock before release, system error is not
   always_ff @(posedge clock) begin
      if (srst) begin
         perr_phase_reg <= 2'd0;
         perr_n <= 1'b1;
         perr_oe <= 1'b0;
      end else if (data_perr && cfg_bus.perr_resp) begin
         perr_phase_reg <= 2'd2;
         perr_n <= 1'b0; // R12 R13
         perr_oe <= 1'b1;
      end else if (perr_phase_reg == 2'd2) begin
         perr_phase_reg <= 2'd1;
         perr_n <= 1'b1; // R17
      end else if (perr_phase_reg == 2'd1) begin
         perr_phase_reg <= 2'd0;
         perr_oe <= 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         system_error_out_n <= 1'b0;
         system_error_oe <= 1'b0; // R2
      end else begin
         // open drain: the level never changes, only the enable
         system_error_oe <= cfg_bus.serr_evt; // R14
      end
   end
   // ==================================================================
   // lock is only watched: exported while held during an own claim
   always_ff @(posedge clock) begin
      if (srst) begin
         atomic_active <= 1'b0;
      end else if (state_reg == pcitgt_pkg::PT_DECODE) begin
         atomic_active <= hit && !lock_n; // R9
      end else if (lock_n && frame_n) begin
         atomic_active <= 1'b0; // R9
      end
   end
   // ==================================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   reset_float_a: assert property (disable iff (1'b0) // R2
      $past(srst) |-> !ad_oe && !system_error_oe && !devsel_oe)
      else $error("pins driven after reset");
   cfg_idsel_a: assert property ( // R10
      state_reg == pcitgt_pkg::PT_DECODE && cmd_is_cfg(cmd_reg) &&
      !idsel_reg |=> !devsel_oe)
      else $error("config claimed without id select");
   devsel_claim_a: assert property ( // R11
      state_reg == pcitgt_pkg::PT_DECODE && hit |=> !devsel_n &&
      devsel_oe ##1 !devsel_n && devsel_oe)
      else $error("device select not held after decode");
   trdy_ready_a: assert property ( // R7
      !trdy_n && trdy_oe |-> !devsel_n && ($past(state_reg) ==
      pcitgt_pkg::PT_DATA || state_reg == pcitgt_pkg::PT_XFER))
      else $error("target ready outside data phase");
   stop_with_trdy_a: assert property ( // R8
      $fell(trdy_n) |-> $fell(stop_n))
      else $error("stop not raised with the single data phase");
   write_capture_a: assert property ( // R4
      io_wr |-> $past(!irdy_n && !trdy_n) && io_wdata == $past(ad_in))
      else $error("write taken without both ready lines");
   perr_width_a: assert property ( // R13
      $fell(perr_n) |-> perr_oe ##1 perr_n && perr_oe ##1 !perr_oe)
      else $error("parity error pulse shape wrong");
   serr_addr_a: assert property ( // R14
      system_error_oe |-> $past(addr_perr) && !system_error_out_n)
      else $error("system error without address parity fault");
   release_high_a: assert property ( // R17
      $fell(devsel_oe) |-> $past(devsel_n) && $past(trdy_n) &&
      $past(stop_n))
      else $error("target pins released while low");
   read_parity_a: assert property ( // R15
      ad_oe && !trdy_n && !irdy_n |=> par_oe && par_out ==
      ^{$past(ad_out), $past(cbe_n)})
      else $error("read parity wrong");
   cfg_read_c: cover property (state_reg == pcitgt_pkg::PT_XFER &&
      xfer && is_cfg_reg && is_read_reg);
   io_write_c: cover property (io_wr);
   perr_c: cover property ($fell(perr_n));
   serr_c: cover property (system_error_oe);
endmodule
`default_nettype wire

// ---- tb/pcitgt_init.sv ----
// bus initiator model: one dword per transaction, parity a clock behind
`timescale 1ns/10ps
`default_nettype none
module pcitgt_init (
   input wire logic clock,
   output logic [31:0] ad_drv,
   output logic [3:0] cbe_n,
   output logic par_in,
   output logic frame_n,
   output logic irdy_n,
   output logic lock_n,
   output logic idsel,
   input wire logic [31:0] ad_bus,
   input wire logic trdy_n,
   input wire logic stop_n,
   input wire logic devsel_n,
   input wire logic devsel_oe,
   input wire logic par_out
);
   logic flip;
   initial begin
      ad_drv = 32'h0;
      cbe_n = 4'hF;
      par_in = 1'b0;
      frame_n = 1'b1;
      irdy_n = 1'b1;
      lock_n = 1'b1;
      idsel = 1'b0;
      flip = 1'b0;
   end
   // ==========================================================
   // parity
   // flip spoils exactly the phase chosen by the caller
   always @(negedge clock) begin
      par_in <= ^{ad_bus, cbe_n} ^ flip;
   end
   // ==========================================================
   // transaction
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
         input logic [31:0] wd, input logic [3:0] be, input logic sel,
         input logic lk, input logic bap, input logic bdp,
         output logic [31:0] rd, output logic cl, output logic ok);
      int n;
      n = 0;
      cl = 1'b0;
      rd = 32'h0;
      @(negedge clock);
      frame_n <= 1'b0;
      ad_drv <= addr;
      cbe_n <= cmd;
      idsel <= sel;
      lock_n <= ~lk;
      flip <= bap;
      @(negedge clock);
      frame_n <= 1'b1;
      irdy_n <= 1'b0;
      ad_drv <= cmd[0] ? wd : ~addr;
      cbe_n <= be;
      idsel <= 1'b0;
      flip <= bdp;
      // unclaimed cycles end as a master abort after 8 clocks
      while (n < 8 && !cl) begin
         @(posedge clock);
         cl = (devsel_n === 1'b0 && trdy_n === 1'b0);
         n++;
      end
      rd = ad_bus;
      ok = (stop_n === 1'b0);
      @(negedge clock);
      irdy_n <= 1'b1;
      ad_drv <= ~ad_bus;
      flip <= 1'b0;
      @(posedge clock);
      ok = ok && devsel_oe === 1'b1 && devsel_n === 1'b1;
      if (!cmd[0]) ok = ok && par_out === ^{rd, be};
      @(posedge clock);
      ok = ok && devsel_oe === 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// bench for the bus target: initiator model, backend stub, checks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clock, srst, ad_oe, par_in, par_out, par_oe, frame_n, irdy_n;
   logic lock_n, idsel, trdy_n, trdy_oe, stop_n, stop_oe, devsel_n;
   logic devsel_oe, perr_n, perr_oe, serr_n, serr_oe, io_rd, io_wr;
   logic atomic_active, cl, ok;
   logic [31:0] ad_drv, ad_out, io_rdata, io_wdata, wd_seen, rd;
   logic [3:0] cbe_n, io_be_n, be_seen;
   logic [4:0] io_addr, addr_seen;
   int fails, samples_checked, cycles, perr_cnt, serr_cnt, wr_cnt, p;
   int rd_cnt;
   // pulled-up target pins read high once released
   wire logic [31:0] ad_bus = ad_oe ? ad_out : ad_drv;
   wire logic trdy_w = trdy_oe ? trdy_n : 1'b1;
   wire logic stop_w = stop_oe ? stop_n : 1'b1;
   wire logic devsel_w = devsel_oe ? devsel_n : 1'b1;
   pcitgt_top #(.IO_BITS(5)) pcitgt_top_inst (.clock(clock), .srst(srst),
      .ad_in(ad_bus), .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n(cbe_n),
      .par_in(par_in), .par_out(par_out), .par_oe(par_oe),
      .frame_n(frame_n), .irdy_n(irdy_n), .lock_n(lock_n), .idsel(idsel),
      .trdy_n(trdy_n), .trdy_oe(trdy_oe), .stop_n(stop_n),
      .stop_oe(stop_oe), .devsel_n(devsel_n), .devsel_oe(devsel_oe),
      .perr_n(perr_n), .perr_oe(perr_oe), .system_error_out_n(serr_n),
      .system_error_oe(serr_oe), .io_rd(io_rd), .io_wr(io_wr),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_be_n(io_be_n),
      .io_rdata(io_rdata), .atomic_active(atomic_active));
   pcitgt_init pcitgt_init_inst (.clock(clock), .ad_drv(ad_drv),
      .cbe_n(cbe_n), .par_in(par_in), .frame_n(frame_n), .irdy_n(irdy_n),
      .lock_n(lock_n), .idsel(idsel), .ad_bus(ad_bus), .trdy_n(trdy_w),
      .stop_n(stop_w), .devsel_n(devsel_w), .devsel_oe(devsel_oe),
      .par_out(par_out));
   // ==========================================================
   // clock, backend stub, monitors
   initial clock = 1'b0;
   always #20 clock = ~clock;
   always @(negedge clock) io_rdata <= 32'hC0DE_0000 | {27'h0, io_addr};
   always @(posedge clock) begin
      if (perr_oe && perr_n === 1'b0) perr_cnt++;
      if (serr_oe && serr_n === 1'b0) serr_cnt++;
      if (io_rd === 1'b1) rd_cnt++;
      if (io_wr === 1'b1) begin
         wr_cnt++;
         addr_seen = io_addr;
         wd_seen = io_wdata;
         be_seen = io_be_n;
      end
      cycles++;
      if (cycles == 1500) begin
         fails++;
         stop_test();
      end
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic go(input logic [3:0] cmd, input logic [31:0] a,
         input logic [31:0] wd, input logic [3:0] be, input logic sel,
         input logic lk, input logic bap, input logic bdp);
      pcitgt_init_inst.xfer(cmd, a, wd, be, sel, lk, bap, bdp, rd, cl, ok);
   endtask
   task automatic stop_test;
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_cfg;
      go(4'hA, 32'h0, 32'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      check({31'h0, cl}, 32'h1);
      check(rd, 32'h1_0F0F);
      check({31'h0, ok}, 32'h1);
      go(4'hA, 32'h0, 32'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check({31'h0, cl}, 32'h0);
      go(4'hB, 32'h10, 32'h100, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      // upper lanes off so the status bits are not touched
      go(4'hB, 32'h4, 32'hFFFF_0141, 4'hC, 1'b1, 1'b0, 1'b0, 1'b0);
      go(4'hA, 32'h10, 32'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      check(rd, 32'h101);
   endtask
   task automatic t_io;
      go(4'h3, 32'h104, 32'hA5A5_5A5A, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
      check({addr_seen, be_seen}, {5'h04, 4'h3});
      check(wd_seen, 32'hA5A5_5A5A);
      check(wr_cnt, 32'h1);
      go(4'h2, 32'h108, 32'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check(rd, 32'hC0DE_0008);
      check(rd_cnt, 32'h1);
      check({31'h0, ok}, 32'h1);
      go(4'h3, 32'h120, 32'h1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check({31'h0, cl}, 32'h0);
      go(4'h1, 32'h100, 32'h1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check({31'h0, cl}, 32'h0);
      check(wr_cnt, 32'h1);
   endtask
   task automatic t_parity;
      p = perr_cnt;
      go(4'h3, 32'h100, 32'h5, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      // the pulse is counted at the edge the transfer returns on
      @(negedge clock);
      check(perr_cnt - p, 32'h1);
      p = serr_cnt;
      go(4'h3, 32'h100, 32'h5, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      check(serr_cnt - p, 32'h1);
      go(4'hA, 32'h4, 32'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      check(rd, 32'hC000_0141);
      go(4'hB, 32'h4, 32'hC000_0141, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      go(4'hA, 32'h4, 32'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      check(rd, 32'h0000_0141);
   endtask
   task automatic t_lock;
      go(4'h3, 32'h100, 32'h7, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
      check({31'h0, atomic_active}, 32'h1);
      go(4'h3, 32'h100, 32'h7, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check({31'h0, atomic_active}, 32'h0);
   endtask
   initial begin
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      perr_cnt = 0;
      serr_cnt = 0;
      wr_cnt = 0;
      rd_cnt = 0;
      srst = 1'b1;
      io_rdata = 32'h0;
      repeat (10) @(negedge clock);
      check({ad_oe, serr_oe}, 32'h0);
      srst = 1'b0;
      @(negedge clock);
      check({ad_oe, par_oe, trdy_oe, stop_oe, devsel_oe, perr_oe}, 32'h0);
      t_cfg();
      t_io();
      t_parity();
      t_lock();
      stop_test();
   end
endmodule
`default_nettype wire
